// File: cfm_pkg.sv
// shared constants and types for the counter frequency and period meter
package cfm_pkg;

  // ----------------------------------------------------------------
  // clocking and timebase
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned ONBOARD_TIMEBASE_HZ = 100_000_000;
  localparam int unsigned ONBOARD_TICK_DIV = CLK_HZ / ONBOARD_TIMEBASE_HZ;
  localparam logic [2:0] TIMEBASE_ONBOARD = 3'h0;
  localparam logic [2:0] FREQ_INPUT_DEFAULT = 3'h0;

  // ----------------------------------------------------------------
  // counters and widths
  // ----------------------------------------------------------------
  localparam int COUNTERS = 8;
  localparam int COUNT_W = 32;
  localparam int TERMINALS = 8;
  localparam logic [31:0] COUNT_MAX = 32'hffffffff;
  localparam logic [31:0] COUNT_RESET = 32'h00000000;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  // ----------------------------------------------------------------
  // modes, timings, methods, point kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_FREQ = 2'h0;
  localparam logic [1:0] MODE_PULSE = 2'h1;
  localparam logic [1:0] MODE_SEMI = 2'h2;
  localparam logic [1:0] TIM_ONDEMAND = 2'h0;
  localparam logic [1:0] TIM_IMPLICIT = 2'h1;
  localparam logic [1:0] TIM_SAMPLE = 2'h2;
  localparam logic [1:0] METH_SAMPLE = 2'h0;
  localparam logic [1:0] METH_LOW = 2'h1;
  localparam logic [1:0] METH_LARGE = 2'h2;
  localparam logic [1:0] METH_HIGH = 2'h3;
  localparam logic [1:0] KIND_FREQ = 2'h0;
  localparam logic [1:0] KIND_PAIR = 2'h1;
  localparam logic [1:0] KIND_HIGH = 2'h2;
  localparam logic [1:0] KIND_LOW = 2'h3;

  // ----------------------------------------------------------------
  // state records
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_ARM, ST_FIRST, ST_SECOND, ST_RUN, ST_HOLD} cfm_phase_t;

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic rise;
    logic fall;
  } cfm_sync_state_t;

  typedef struct packed {
    cfm_phase_t phase;
    logic [31:0] cur;
    logic cur_ovf;
    logic [31:0] span;
    logic [31:0] period_cnt;
    logic [31:0] last_high;
    logic [31:0] last_low;
    logic have_pulse;
    logic [31:0] last_period;
    logic have_period;
    logic out_valid;
    logic [31:0] out_first;
    logic [31:0] out_second;
    logic [1:0] out_kind;
    logic out_ovf;
    logic ovf_flag;
    logic config_error;
    logic two_counter;
    logic [2:0] partner;
  } cfm_state_t;

endpackage : cfm_pkg

// File: cfm_edge_if.sv
// carrier for a synchronised input level and its edges
`timescale 1ns/1ps
`default_nettype none
interface cfm_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : cfm_edge_if
`default_nettype wire

// File: cfm_edge_sync.sv
// three-flop input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module cfm_edge_sync
  import cfm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic raw,
  cfm_edge_if.src edge_out
);

  cfm_sync_state_t s;
  cfm_sync_state_t next_s;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.sync = {s.sync[1:0], raw};
    next_s.rise = 1'b0;
    next_s.fall = 1'b0;
    if (s.sync[1] == s.sync[2])
    begin
      next_s.level = s.sync[2];
      next_s.rise = s.sync[2] & ~s.level;
      next_s.fall = ~s.sync[2] & s.level;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= '{sync: SYNC_RESET, level: 1'b0, rise: 1'b0, fall: 1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign edge_out.level = s.level;
  assign edge_out.rise = s.rise;
  assign edge_out.fall = s.fall;

endmodule : cfm_edge_sync
`default_nettype wire

// File: cfm_meter.sv
// counter channel: pulse, semi-period and frequency measurement, single- and two-counter methods
`timescale 1ns/1ps
`default_nettype none
module cfm_meter
  import cfm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] programmable_function_input,
  input wire logic [7:0] timebase_terminal,
  input wire logic sample_clock,
  input wire logic measure_enable,
  input wire logic read_request,
  input wire logic [1:0] meas_mode_select,
  input wire logic [1:0] timing_select,
  input wire logic [1:0] freq_method_select,
  input wire logic averaging_enable,
  input wire logic starting_edge_falling,
  input wire logic [2:0] freq_input_select,
  input wire logic [2:0] half_period_input_select,
  input wire logic [2:0] timebase_source_select,
  input wire logic [2:0] counter_index,
  input wire logic [31:0] period_target,
  input wire logic [31:0] meas_time_ticks,
  input wire logic overflow_clear,
  output logic result_valid,
  output logic [31:0] result_first,
  output logic [31:0] result_second,
  output logic [1:0] result_kind,
  output logic result_overflow,
  output logic overflow_flag,
  output logic config_error,
  output logic two_counter_method,
  output logic [2:0] partner_index
);

  // ----------------------------------------------------------------
  // input selection and synchronisation
  // ----------------------------------------------------------------
  cfm_edge_if sig_if ();
  cfm_edge_if tb_if ();
  cfm_edge_if smp_if ();

  logic sig_raw;
  logic tb_raw;

  // frequency terminal in frequency mode, half-period terminal otherwise
  assign sig_raw = (meas_mode_select == MODE_FREQ) ?
    programmable_function_input[freq_input_select] :
    programmable_function_input[half_period_input_select];
  assign tb_raw = timebase_terminal[timebase_source_select];

  cfm_edge_sync u_sig_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .raw(sig_raw),
    .edge_out(sig_if.src)
  );

  cfm_edge_sync u_tb_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .raw(tb_raw),
    .edge_out(tb_if.src)
  );

  cfm_edge_sync u_smp_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .raw(sample_clock),
    .edge_out(smp_if.src)
  );

  logic tick;
  logic start_edge;
  logic mid_edge;
  logic sample_edge;

  // onboard clock ticks every cycle at 100 MHz
  assign tick = (timebase_source_select == TIMEBASE_ONBOARD) ? 1'b1 : tb_if.rise;
  assign start_edge = starting_edge_falling ? sig_if.fall : sig_if.rise;
  assign mid_edge = starting_edge_falling ? sig_if.rise : sig_if.fall;
  assign sample_edge = smp_if.rise;

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic is_freq;
  logic is_semi;
  logic is_pulse_like;
  logic timed_by_sample;
  logic two_ctr;
  logic cfg_bad;

  assign is_freq = (meas_mode_select == MODE_FREQ);
  assign is_semi = (meas_mode_select == MODE_SEMI);
  assign is_pulse_like = (meas_mode_select == MODE_PULSE) || is_semi;
  assign timed_by_sample = (timing_select == TIM_SAMPLE) && !is_semi;
  assign two_ctr = is_freq && (freq_method_select == METH_LARGE ||
    freq_method_select == METH_HIGH);
  assign cfg_bad = (is_semi && timing_select == TIM_SAMPLE) ||
    (is_freq && freq_method_select == METH_SAMPLE && timing_select != TIM_SAMPLE) ||
    (two_ctr && counter_index[0]) ||
    (meas_mode_select == 2'h3);

  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (v == COUNT_MAX) ? v : v + 32'h1;
  endfunction : sat_inc

  // ----------------------------------------------------------------
  // measurement state machine
  // ----------------------------------------------------------------
  cfm_state_t s;
  cfm_state_t next_s;

  always_comb
  begin
    logic emit;
    logic e_ovf;
    logic ovf_set;
    logic [31:0] e_first;
    logic [31:0] e_second;
    logic [1:0] e_kind;
    logic [31:0] per;
    emit = 1'b0;
    e_ovf = 1'b0;
    ovf_set = 1'b0;
    e_first = COUNT_RESET;
    e_second = COUNT_RESET;
    e_kind = KIND_FREQ;
    per = COUNT_RESET;
    next_s = s;
    next_s.out_valid = 1'b0;
    next_s.config_error = cfg_bad;
    next_s.two_counter = two_ctr;
    next_s.partner = {counter_index[2:1], ~counter_index[0]};
    // saturating tick count of the running duration
    if (tick && (s.phase == ST_FIRST || s.phase == ST_SECOND || s.phase == ST_RUN))
    begin
      next_s.cur = sat_inc(s.cur);
      if (s.cur == COUNT_MAX)
      begin
        next_s.cur_ovf = 1'b1;
        ovf_set = 1'b1;
      end
    end
    unique case (s.phase)
      ST_IDLE:
      begin
        next_s.phase = ST_ARM;
      end
      ST_ARM:
      begin
        next_s.cur = COUNT_RESET;
        next_s.cur_ovf = 1'b0;
        next_s.span = COUNT_RESET;
        next_s.period_cnt = COUNT_RESET;
        next_s.have_pulse = 1'b0;
        next_s.have_period = 1'b0;
        if (start_edge)
        begin
          next_s.phase = is_pulse_like ? ST_FIRST : ST_RUN;
        end
      end
      ST_FIRST:
      begin
        if (mid_edge)
        begin
          next_s.last_high = next_s.cur;
          next_s.cur = COUNT_RESET;
          next_s.cur_ovf = 1'b0;
          next_s.phase = ST_SECOND;
          if (is_semi)
          begin
            emit = 1'b1;
            e_first = next_s.cur;
            e_first = next_s.last_high;
            e_kind = KIND_HIGH;
            e_ovf = s.cur_ovf | ovf_set;
          end
        end
      end
      ST_SECOND:
      begin
        if (start_edge)
        begin
          next_s.last_low = next_s.cur;
          next_s.have_pulse = 1'b1;
          next_s.cur = COUNT_RESET;
          next_s.cur_ovf = 1'b0;
          next_s.phase = ST_FIRST;
          e_ovf = s.cur_ovf | ovf_set;
          if (is_semi)
          begin
            emit = 1'b1;
            e_first = next_s.last_low;
            e_kind = KIND_LOW;
          end
          else if (!timed_by_sample)
          begin
            emit = 1'b1;
            e_first = s.last_high;
            e_second = next_s.last_low;
            e_kind = KIND_PAIR;
          end
        end
      end
      ST_RUN:
      begin
        if (tick && freq_method_select == METH_HIGH)
        begin
          next_s.span = sat_inc(s.span);
        end
        if (start_edge)
        begin
          per = next_s.cur;
          e_ovf = next_s.cur_ovf;
          next_s.period_cnt = sat_inc(s.period_cnt);
          if (freq_method_select != METH_HIGH)
          begin
            next_s.span = s.span + per;
          end
          next_s.last_period = per;
          next_s.have_period = 1'b1;
          next_s.cur = COUNT_RESET;
          next_s.cur_ovf = 1'b0;
        end
        if (timed_by_sample && (freq_method_select == METH_SAMPLE ||
          freq_method_select == METH_LOW))
        begin
          if (sample_edge && averaging_enable && freq_method_select == METH_SAMPLE)
          begin
            emit = 1'b1;
            e_first = next_s.period_cnt;
            e_second = next_s.span;
            next_s.period_cnt = COUNT_RESET;
            next_s.span = COUNT_RESET;
          end
          else if (sample_edge && next_s.have_period)
          begin
            emit = 1'b1;
            e_first = next_s.last_period;
          end
        end
        else if (freq_method_select == METH_LOW && start_edge && !timed_by_sample)
        begin
          emit = 1'b1;
          e_first = 32'h1;
          e_second = per;
        end
        else if (freq_method_select == METH_LARGE && start_edge &&
          next_s.period_cnt >= period_target)
        begin
          emit = 1'b1;
          e_first = next_s.period_cnt;
          e_second = next_s.span;
          next_s.period_cnt = COUNT_RESET;
          next_s.span = COUNT_RESET;
        end
        else if (freq_method_select == METH_HIGH && meas_time_ticks != COUNT_RESET &&
          next_s.span >= meas_time_ticks)
        begin
          emit = 1'b1;
          e_first = next_s.period_cnt;
          e_second = next_s.span;
          next_s.period_cnt = COUNT_RESET;
          next_s.span = COUNT_RESET;
        end
      end
      ST_HOLD:
      begin
        // signal ignored until the result is read
        if (read_request)
        begin
          next_s.phase = ST_ARM;
        end
      end
      default:
      begin
        next_s.phase = ST_IDLE;
      end
    endcase
    // paced pulse pair: most recent full pulse at each sample edge
    if (timed_by_sample && !is_freq && sample_edge && s.have_pulse &&
      (s.phase == ST_FIRST || s.phase == ST_SECOND))
    begin
      emit = 1'b1;
      e_first = s.last_high;
      e_second = s.last_low;
      e_kind = KIND_PAIR;
      e_ovf = 1'b0;
    end
    if (emit)
    begin
      next_s.out_valid = 1'b1;
      next_s.out_first = e_first;
      next_s.out_second = e_second;
      next_s.out_kind = e_kind;
      next_s.out_ovf = e_ovf;
      if (timing_select == TIM_ONDEMAND && !(is_semi && e_kind == KIND_HIGH))
      begin
        next_s.phase = ST_HOLD;
      end
    end
    if (!measure_enable || cfg_bad)
    begin
      next_s.phase = ST_IDLE;
      next_s.out_valid = 1'b0;
    end
    // set wins over software clear
    next_s.ovf_flag = (s.ovf_flag & ~overflow_clear) | ovf_set;
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= '{phase: ST_IDLE, cur: COUNT_RESET, cur_ovf: 1'b0, span: COUNT_RESET,
        period_cnt: COUNT_RESET, last_high: COUNT_RESET, last_low: COUNT_RESET,
        have_pulse: 1'b0, last_period: COUNT_RESET, have_period: 1'b0,
        out_valid: 1'b0, out_first: COUNT_RESET, out_second: COUNT_RESET,
        out_kind: KIND_FREQ, out_ovf: 1'b0, ovf_flag: 1'b0, config_error: 1'b0,
        two_counter: 1'b0, partner: 3'h0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign result_valid = s.out_valid;
  assign result_first = s.out_first;
  assign result_second = s.out_second;
  assign result_kind = s.out_kind;
  assign result_overflow = s.out_ovf;
  assign overflow_flag = s.ovf_flag;
  assign config_error = s.config_error;
  assign two_counter_method = s.two_counter;
  assign partner_index = s.partner;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_semi_points: assert property (result_valid && is_semi |->
    result_second == COUNT_RESET && (result_kind == KIND_HIGH || result_kind == KIND_LOW))
    else $error("semi point not single");
  a_pulse_pair: assert property (result_valid && meas_mode_select == MODE_PULSE |->
    result_kind == KIND_PAIR) else $error("pulse point not paired");
  a_semi_no_sample: assert property (is_semi && timing_select == TIM_SAMPLE |=>
    config_error && !result_valid) else $error("semi accepted sample clock");
  a_avg_on_sample: assert property (s.phase == ST_RUN && is_freq && timed_by_sample &&
    freq_method_select == METH_SAMPLE && averaging_enable && sample_edge && measure_enable
    && !cfg_bad |=> result_valid && result_kind == KIND_FREQ && s.span == COUNT_RESET &&
    s.period_cnt == COUNT_RESET) else $error("averaged sample missing");
  a_noavg_single: assert property (result_valid && $past(is_freq && timed_by_sample &&
    !averaging_enable) |-> result_second == COUNT_RESET)
    else $error("non-averaged carried extra count");
  a_one_per_sample: assert property (result_valid && $past(is_freq && timed_by_sample) |->
    $past(sample_edge)) else $error("result without sample clock");
  a_large_count: assert property (result_valid && $past(is_freq &&
    freq_method_select == METH_LARGE) |-> result_first >= $past(period_target, 2))
    else $error("large range delivered early");
  a_high_time: assert property (result_valid && $past(is_freq &&
    freq_method_select == METH_HIGH) |-> result_second >= $past(meas_time_ticks, 2))
    else $error("measurement time not elapsed");
  a_partner_pair: assert property ($past(reset_n) |-> partner_index[2:1] ==
    $past(counter_index[2:1]) && partner_index[0] != $past(counter_index[0]))
    else $error("partner not adjacent");
  a_ovf_sticky: assert property (overflow_flag && !overflow_clear |=> overflow_flag)
    else $error("overflow flag lost");
  a_hold_quiet: assert property (s.phase == ST_HOLD && !read_request && measure_enable
    |=> !result_valid [*1]) else $error("result while holding");
  a_onboard_tick: assert property (s.phase == ST_FIRST && !mid_edge &&
    timebase_source_select == TIMEBASE_ONBOARD && s.cur != COUNT_MAX |=>
    s.cur == $past(s.cur) + 32'h1) else $error("onboard timebase idle");

  c_pulse_pair: cover property (result_valid && result_kind == KIND_PAIR);
  c_semi_low: cover property (result_valid && result_kind == KIND_LOW);
  c_freq_avg: cover property (result_valid && result_kind == KIND_FREQ &&
    result_second != COUNT_RESET);
  c_overflow: cover property ($rose(overflow_flag));

endmodule : cfm_meter
`default_nettype wire

// File: cfm_meter_end.sv
// intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: cfm_signal_model.sv
// far-side model: measured pulse train and sample clock
`timescale 1ns/1ps
`default_nettype none
module cfm_signal_model
(
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [15:0] high_len,
  input wire logic [15:0] low_len,
  input wire logic [15:0] sample_every,
  output logic sig,
  output logic sample_clock
);
  // ----------------------------------------------------------------
  // pulse train, starts low, high_len cycles high, low_len low
  // ----------------------------------------------------------------
  logic [15:0] cnt;
  logic [15:0] scnt;
  initial sig = 1'b0;
  initial sample_clock = 1'b0;
  initial cnt = 16'h0000;
  initial scnt = 16'h0000;
  always @(posedge clk_sys)
  begin
    if (!run)
    begin
      sig <= 1'b0;
      cnt <= 16'h0000;
      scnt <= 16'h0000;
      sample_clock <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 16'h0001;
      if (!sig && cnt >= low_len - 16'h0001)
      begin
        sig <= 1'b1;
        cnt <= 16'h0000;
      end
      if (sig && cnt >= high_len - 16'h0001)
      begin
        sig <= 1'b0;
        cnt <= 16'h0000;
      end
      // sample clock: 4 cycles high at the end of each sample_every span
      scnt <= (scnt + 16'h0001 >= sample_every) ? 16'h0000 : scnt + 16'h0001;
      sample_clock <= (sample_every != 16'h0000) && (scnt >= sample_every - 16'h0004);
    end
  end
endmodule : cfm_signal_model
`default_nettype wire

// File: cfm_meter_tb.sv
// self-checking testbench for the counter channel
`timescale 1ns/1ps
`default_nettype none
module cfm_meter_tb
  import cfm_pkg::*;
;
  logic clk_sys, reset_n, sig, sample_clock, run, measure_enable, read_request;
  logic averaging_enable, starting_edge_falling, overflow_clear;
  logic [1:0] meas_mode_select, timing_select, freq_method_select, result_kind;
  logic [2:0] freq_input_select, half_period_input_select, timebase_source_select;
  logic [2:0] counter_index, partner_index;
  logic [7:0] timebase_terminal;
  logic [31:0] period_target, meas_time_ticks, result_first, result_second;
  logic result_valid, result_overflow, overflow_flag, config_error, two_counter_method;
  logic [15:0] hi, lo, samp, tb_div;
  logic samp_prev;
  logic [65:0] res_q[$];
  int fail_count, n_tests, n_samp;

  cfm_signal_model cfm_signal_model_i (.clk_sys(clk_sys), .run(run), .high_len(hi),
    .low_len(lo), .sample_every(samp), .sig(sig), .sample_clock(sample_clock));
  cfm_meter cfm_meter_i (.clk_sys(clk_sys), .reset_n(reset_n),
    .programmable_function_input({5'h00, sig, 1'b0, sig}), .timebase_terminal(timebase_terminal),
    .sample_clock(sample_clock), .measure_enable(measure_enable), .read_request(read_request),
    .meas_mode_select(meas_mode_select), .timing_select(timing_select),
    .freq_method_select(freq_method_select), .averaging_enable(averaging_enable),
    .starting_edge_falling(starting_edge_falling), .freq_input_select(freq_input_select),
    .half_period_input_select(half_period_input_select),
    .timebase_source_select(timebase_source_select), .counter_index(counter_index),
    .period_target(period_target), .meas_time_ticks(meas_time_ticks),
    .overflow_clear(overflow_clear), .result_valid(result_valid), .result_first(result_first),
    .result_second(result_second), .result_kind(result_kind),
    .result_overflow(result_overflow), .overflow_flag(overflow_flag),
    .config_error(config_error), .two_counter_method(two_counter_method),
    .partner_index(partner_index));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // monitors: results, sample edges, slow timebase terminal
  // ----------------------------------------------------------------
  always @(negedge clk_sys)
  begin
    if (result_valid === 1'b1)
      res_q.push_back({result_kind, result_first, result_second});
  end

  always @(posedge clk_sys)
  begin
    samp_prev <= sample_clock;
    if (sample_clock && !samp_prev)
      n_samp++;
    tb_div <= tb_div + 16'h0001;
    timebase_terminal <= {6'h00, tb_div[1], 1'b0};
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic setup(input logic [1:0] md, input logic [1:0] tm, input logic [1:0] mt,
                       input logic av, input logic [15:0] h, input logic [15:0] l,
                       input logic [15:0] s);
    @(posedge clk_sys);
    measure_enable <= 1'b0;
    run <= 1'b0;
    repeat (4) @(posedge clk_sys);
    meas_mode_select <= md;
    timing_select <= tm;
    freq_method_select <= mt;
    averaging_enable <= av;
    hi <= h;
    lo <= l;
    samp <= s;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    res_q.delete();
    n_samp = 0;
    @(posedge clk_sys);
    measure_enable <= 1'b1;
    run <= 1'b1;
  endtask : setup

  task automatic wait_res(input int n);
    int k;
    k = 0;
    while (res_q.size() < n && k < 3000)
    begin
      @(posedge clk_sys);
      k++;
    end
    check("result count", res_q.size() >= n, 32'h1);
  endtask : wait_res

  task automatic res_is(input int i, input logic [1:0] k, input logic [31:0] f,
                        input logic [31:0] s);
    check("result kind", {30'h0, res_q[i][65:64]}, {30'h0, k});
    check("result first", res_q[i][63:32], f);
    check("result second", res_q[i][31:0], s);
  endtask : res_is

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset_n = 1'b0;
    run = 1'b0;
    measure_enable = 1'b0;
    read_request = 1'b0;
    averaging_enable = 1'b0;
    starting_edge_falling = 1'b0;
    overflow_clear = 1'b0;
    meas_mode_select = MODE_FREQ;
    timing_select = TIM_IMPLICIT;
    freq_method_select = METH_LOW;
    freq_input_select = FREQ_INPUT_DEFAULT;
    half_period_input_select = 3'h2;
    timebase_source_select = TIMEBASE_ONBOARD;
    counter_index = 3'h0;
    period_target = 32'h00000004;
    meas_time_ticks = 32'h00000064;
    timebase_terminal = 8'h00;
    hi = 16'h0005;
    lo = 16'h0005;
    samp = 16'h0000;
    tb_div = 16'h0000;
    samp_prev = 1'b0;
    fail_count = 0;
    n_tests = 0;
    n_samp = 0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    freq_method_select <= METH_LARGE;
    for (int i = 0; i < 8; i++)
    begin
      counter_index <= i[2:0];
      repeat (3) @(posedge clk_sys);
      check("two counter", {31'h0, two_counter_method}, 32'h1);
      check("partner", {29'h0, partner_index}, {29'h0, i[2:0] ^ 3'h1});
      check("odd pair error", {31'h0, config_error}, {31'h0, i[0]});
    end
    counter_index <= 3'h0;
    setup(MODE_SEMI, TIM_SAMPLE, METH_SAMPLE, 1'b0, 16'h0006, 16'h0009, 16'h0000);
    repeat (3) @(posedge clk_sys);
    check("semi sample refused", {31'h0, config_error}, 32'h1);
    setup(MODE_PULSE, TIM_SAMPLE, METH_SAMPLE, 1'b0, 16'h0006, 16'h0009, 16'h0000);
    repeat (3) @(posedge clk_sys);
    check("pulse sample allowed", {31'h0, config_error}, 32'h0);
    setup(MODE_PULSE, TIM_IMPLICIT, METH_SAMPLE, 1'b0, 16'h0006, 16'h0009, 16'h0000);
    wait_res(2);
    res_is(0, KIND_PAIR, 32'h6, 32'h9);
    res_is(1, KIND_PAIR, 32'h6, 32'h9);
    setup(MODE_SEMI, TIM_IMPLICIT, METH_SAMPLE, 1'b0, 16'h0006, 16'h0009, 16'h0000);
    wait_res(3);
    res_is(0, KIND_HIGH, 32'h6, 32'h0);
    res_is(1, KIND_LOW, 32'h9, 32'h0);
    setup(MODE_FREQ, TIM_SAMPLE, METH_SAMPLE, 1'b1, 16'h0005, 16'h0005, 16'h00c8);
    wait_res(3);
    res_is(1, KIND_FREQ, 32'h14, 32'hc8);
    @(negedge sample_clock);
    @(posedge clk_sys);
    samp <= 16'h0000;
    repeat (20) @(posedge clk_sys);
    check("one result per sample", res_q.size(), n_samp);
    setup(MODE_FREQ, TIM_SAMPLE, METH_SAMPLE, 1'b0, 16'h0005, 16'h0005, 16'h00c8);
    wait_res(2);
    res_is(1, KIND_FREQ, 32'ha, 32'h0);
    setup(MODE_FREQ, TIM_IMPLICIT, METH_LOW, 1'b0, 16'h0007, 16'h0008, 16'h0000);
    wait_res(2);
    res_is(1, KIND_FREQ, 32'h1, 32'hf);
    setup(MODE_FREQ, TIM_IMPLICIT, METH_LARGE, 1'b0, 16'h0005, 16'h0005, 16'h0000);
    wait_res(2);
    res_is(1, KIND_FREQ, 32'h4, 32'h28);
    setup(MODE_FREQ, TIM_IMPLICIT, METH_HIGH, 1'b0, 16'h0005, 16'h0005, 16'h0000);
    wait_res(2);
    res_is(1, KIND_FREQ, 32'ha, 32'h64);
    setup(MODE_PULSE, TIM_ONDEMAND, METH_SAMPLE, 1'b0, 16'h0006, 16'h0009, 16'h0000);
    wait_res(1);
    repeat (60) @(posedge clk_sys);
    check("on demand hold", res_q.size(), 32'h1);
    read_request <= 1'b1;
    @(posedge clk_sys);
    read_request <= 1'b0;
    wait_res(2);
    res_is(1, KIND_PAIR, 32'h6, 32'h9);
    timebase_source_select <= 3'h1;
    setup(MODE_FREQ, TIM_IMPLICIT, METH_LOW, 1'b0, 16'h0014, 16'h0014, 16'h0000);
    wait_res(2);
    res_is(1, KIND_FREQ, 32'h1, 32'ha);
    check("overflow flag", {31'h0, overflow_flag}, 32'h0);
    check("point overflow", {31'h0, result_overflow}, 32'h0);
    report_and_stop();
  end

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    fail_count++;
    report_and_stop();
  end
endmodule : cfm_meter_tb
`default_nettype wire
